// >>> rtl/asc_map.svh
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH
// ==========================================
// register offsets (byte addresses)
`define ASC_OFF_CON1 8'h00
`define ASC_OFF_CON2 8'h04
`define ASC_OFF_CON3 8'h08
`define ASC_OFF_PCFGL 8'h0c
`define ASC_OFF_PCFGH 8'h10
`define ASC_OFF_STAT 8'h14
`define ASC_OFF_PMD 8'h18
`define ASC_OFF_CHSEL 8'h1c
`define ASC_BUF_BASE_HI 2'h1
// ==========================================
// field positions
`define ASC_C1_ON 15
`define ASC_C1_RES 10
`define ASC_C1_FORM_HI 9
`define ASC_C1_FORM_LO 8
`define ASC_C1_SSRC_HI 7
`define ASC_C1_SSRC_LO 5
`define ASC_C1_ASAM 2
`define ASC_C1_SAMP 1
`define ASC_C1_DONE 0
`define ASC_C2_VCFG_HI 15
`define ASC_C2_VCFG_LO 13
`define ASC_C2_SCAN 10
`define ASC_C2_CHPS_HI 9
`define ASC_C2_CHPS_LO 8
`define ASC_C2_BUFS 7
`define ASC_C2_SMPI_HI 5
`define ASC_C2_SMPI_LO 2
`define ASC_C2_BUFM 1
`define ASC_C3_SAMC_HI 12
`define ASC_C3_SAMC_LO 8
`define ASC_C3_ADCS_HI 7
`define ASC_C3_ADCS_LO 0
// ==========================================
// reset values and codes
`define ASC_RST_WORD 16'h0000
`define ASC_SSRC_MANUAL 3'h0
`define ASC_SSRC_AUTO 3'h7
// ==========================================
// timing: conversion length in tad, least tad in ns, clock in MHz
`define ASC_CONV_TAD10 5'h0c
`define ASC_CONV_TAD12 5'h0e
`define ASC_CLK_MHZ 40
`define ASC_TAD_MIN10_NS 75
`define ASC_TAD_MIN12_NS 150
`define ASC_TAD_MIN10_CYC ((`ASC_TAD_MIN10_NS * `ASC_CLK_MHZ + 999) / 1000)
`define ASC_TAD_MIN12_CYC ((`ASC_TAD_MIN12_NS * `ASC_CLK_MHZ + 999) / 1000)
`endif

// >>> rtl/asc_pkg.sv
package asc_pkg;
  // ==========================================
  // sequencer states and data words
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_STORE} asc_state_t;
  typedef logic [15:0] asc_word_t;
endpackage : asc_pkg

// >>> rtl/asc_top.sv
`timescale 1ns/1ps
`include "asc_map.svh"
// Operation
// - thirteen analog inputs, numbered zero to twelve
// - bit 10 picks 10-bit/4 or 12-bit/1
// - results kept in sixteen word buffer
// - rate capped 1.1 Msps / 500 ksps
// - 10-bit samples up to four inputs together
// - 12-bit never samples more than one input
// - scan, trigger source, buffer fill modes
// - bits 9:8 choose four result formats
// - keeps converting in sleep and idle
// - two external reference inputs, shared pins
// - control two bits 15:13 pick reference
// - control three bits 7:0 set tad
// - control two bits 9:8 set channel count
// - ssrc and samc select sample sequence
// - control one bit 15 switches module on
// - module disable makes all pins digital
module asc_top
  import asc_pkg::*;
#(
  parameter int NUM_AN = 13,
  parameter int BUF_WORDS = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // analog front end
  input wire logic ext_trig,
  input wire logic [11:0] afe_result,
  output logic afe_enable,
  output logic afe_res12,
  output logic [2:0] afe_ref_sel,
  output logic [3:0] afe_sample,
  output logic afe_convert,
  output logic [3:0] afe_channel,
  output logic [NUM_AN-1:0] pin_digital_mode,
  output logic conv_interrupt_flag
);
  // ==========================================
  // declarations
  asc_word_t conv_control_one_ff, conv_control_two_ff, conv_control_three_ff;
  asc_word_t pin_analog_config_low_ff, pin_analog_config_high_ff;
  asc_word_t buf_mem [BUF_WORDS];
  asc_word_t rd_word;
  asc_state_t state_ff;
  logic conv_module_disable_ff, flag_ff, done_ff, samp_ff, half_ff;
  logic wr_pend_ff, enable_ff;
  logic [7:0] wr_addr_ff, div_cnt_ff, tad_div;
  logic [31:0] hrdata_ff;
  logic [3:0] ch0_sel_ff, scan_idx_ff, sample_ff, chan_ff, sh_idx_ff, seq_cnt_ff;
  logic [3:0] wr_ptr_ff, sh_mask;
  logic [4:0] tad_cnt_ff;
  logic [11:0] raw_ff;
  logic convert_ff, tick, module_on, wr_go, sample_end, last_sh;
  logic [NUM_AN-1:0] digital_ff;
  logic [2:0] ssrc;
  logic [4:0] conv_len;

  // ==========================================
  // helpers
  // result formatting for both resolutions
  function automatic asc_word_t fmt(input logic [11:0] raw, input logic r12,
                                    input logic [1:0] form);
    asc_word_t w;
    w = 16'h0000;
    if (r12)
    begin
      case (form)
        2'h0: w = {4'h0, raw};
        2'h1: w = {{5{~raw[11]}}, raw[10:0]};
        2'h2: w = {raw, 4'h0};
        default: w = {~raw[11], raw[10:0], 4'h0};
      endcase
    end
    else
    begin
      case (form)
        2'h0: w = {6'h00, raw[9:0]};
        2'h1: w = {{7{~raw[9]}}, raw[8:0]};
        2'h2: w = {raw[9:0], 6'h00};
        default: w = {~raw[9], raw[8:0], 6'h00};
      endcase
    end
    return w;
  endfunction : fmt

  // next analog-marked input after the current one
  function automatic logic [3:0] next_scan(input logic [3:0] cur,
                                           input logic [NUM_AN-1:0] amask);
    logic [3:0] n;
    logic found;
    n = cur;
    found = 1'b0;
    for (int i = 1; i <= NUM_AN; i++)
    begin
      if (!found && amask[(int'(cur) + i) % NUM_AN])
      begin
        n = 4'((int'(cur) + i) % NUM_AN);
        found = 1'b1;
      end
    end
    return n;
  endfunction : next_scan

  // ==========================================
  // decoded controls
  assign module_on = conv_control_one_ff[`ASC_C1_ON] & ~conv_module_disable_ff;
  assign ssrc = conv_control_one_ff[`ASC_C1_SSRC_HI:`ASC_C1_SSRC_LO];
  assign afe_res12 = conv_control_one_ff[`ASC_C1_RES];
  assign conv_len = afe_res12 ? `ASC_CONV_TAD12 : `ASC_CONV_TAD10;
  // last hold when the ones up to this index fill the mask
  assign last_sh = ((4'h2 << sh_idx_ff) - 4'h1) == sh_mask;
  assign wr_go = hsel & hready & htrans[1];

  // sample-and-hold mask; 12-bit keeps only one
  always_comb
  begin
    sh_mask = 4'h1;
    if (!afe_res12)
    begin
      case (conv_control_two_ff[`ASC_C2_CHPS_HI:`ASC_C2_CHPS_LO])
        2'h0: sh_mask = 4'h1;
        2'h1: sh_mask = 4'h3;
        default: sh_mask = 4'hf;
      endcase
    end
  end

  // tad divider floored so rate never exceeds its cap
  always_comb
  begin
    tad_div = conv_control_three_ff[`ASC_C3_ADCS_HI:`ASC_C3_ADCS_LO];
    if (afe_res12 && tad_div < 8'(`ASC_TAD_MIN12_CYC - 1))
      tad_div = 8'(`ASC_TAD_MIN12_CYC - 1);
    else if (!afe_res12 && tad_div < 8'(`ASC_TAD_MIN10_CYC - 1))
      tad_div = 8'(`ASC_TAD_MIN10_CYC - 1);
  end
  assign tick = div_cnt_ff >= tad_div;

  // end of sampling by trigger source
  always_comb
  begin
    case (ssrc)
      `ASC_SSRC_MANUAL: sample_end = ~samp_ff;
      `ASC_SSRC_AUTO: sample_end = tick &&
        tad_cnt_ff >= conv_control_three_ff[`ASC_C3_SAMC_HI:`ASC_C3_SAMC_LO];
      default: sample_end = ext_trig;
    endcase
  end

  // ==========================================
  // ahb-lite slave: zero wait, always okay
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= wr_go & hwrite;
      wr_addr_ff <= haddr[7:0];
      if (wr_go && !hwrite)
        hrdata_ff <= {16'h0000, rd_word};
    end
  end

  // read mux
  always_comb
  begin
    rd_word = 16'h0000;
    if (haddr[7:6] == `ASC_BUF_BASE_HI)
      rd_word = buf_mem[haddr[5:2]];
    else
    begin
      case (haddr[7:0])
        `ASC_OFF_CON1: rd_word = {conv_control_one_ff[15:2], samp_ff, done_ff};
        `ASC_OFF_CON2: rd_word = {conv_control_two_ff[15:8], half_ff,
                                  conv_control_two_ff[6:0]};
        `ASC_OFF_CON3: rd_word = conv_control_three_ff;
        `ASC_OFF_PCFGL: rd_word = pin_analog_config_low_ff;
        `ASC_OFF_PCFGH: rd_word = pin_analog_config_high_ff;
        `ASC_OFF_STAT: rd_word = {10'h000, state_ff, 2'h0, state_ff != ST_IDLE, flag_ff};
        `ASC_OFF_PMD: rd_word = {15'h0000, conv_module_disable_ff};
        `ASC_OFF_CHSEL: rd_word = {12'h000, ch0_sel_ff};
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // control registers
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      conv_control_one_ff <= `ASC_RST_WORD; // 10-bit default
      conv_control_two_ff <= `ASC_RST_WORD;
      conv_control_three_ff <= `ASC_RST_WORD;
      pin_analog_config_low_ff <= `ASC_RST_WORD;
      pin_analog_config_high_ff <= `ASC_RST_WORD;
      conv_module_disable_ff <= 1'b0;
      ch0_sel_ff <= 4'h0;
    end
    else if (wr_pend_ff)
    begin
      case (wr_addr_ff)
        `ASC_OFF_CON1:
        begin
          conv_control_one_ff <= hwdata[15:0];
          if (conv_control_one_ff[`ASC_C1_ON])
            conv_control_one_ff[`ASC_C1_RES] <= conv_control_one_ff[`ASC_C1_RES];
        end
        `ASC_OFF_CON2: conv_control_two_ff <= hwdata[15:0];
        `ASC_OFF_CON3: conv_control_three_ff <= hwdata[15:0];
        `ASC_OFF_PCFGL: pin_analog_config_low_ff <= hwdata[15:0];
        `ASC_OFF_PCFGH: pin_analog_config_high_ff <= hwdata[15:0];
        `ASC_OFF_PMD: conv_module_disable_ff <= hwdata[0];
        `ASC_OFF_CHSEL: ch0_sel_ff <= (hwdata[3:0] < 4'(NUM_AN)) ? hwdata[3:0] : 4'h0;
        default: ;
      endcase
    end
  end

  // interrupt flag: set wins over software clear
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      flag_ff <= 1'b0;
    else if (state_ff == ST_STORE && last_sh &&
             seq_cnt_ff == conv_control_two_ff[`ASC_C2_SMPI_HI:`ASC_C2_SMPI_LO])
      flag_ff <= 1'b1;
    else if (wr_pend_ff && wr_addr_ff == `ASC_OFF_STAT && !hwdata[0])
      flag_ff <= 1'b0;
  end

  // sample request: a con1 write wins, even the one switching on
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      samp_ff <= 1'b0;
    else if (wr_pend_ff && wr_addr_ff == `ASC_OFF_CON1)
      samp_ff <= hwdata[`ASC_C1_SAMP] & hwdata[`ASC_C1_ON] & ~conv_module_disable_ff;
    else if (!module_on)
      samp_ff <= 1'b0;
    else if (state_ff == ST_SAMPLE && sample_end)
      samp_ff <= 1'b0;
    else if (state_ff == ST_IDLE && conv_control_one_ff[`ASC_C1_ASAM])
      samp_ff <= 1'b1;
  end

  // tad divider
  always_ff @(posedge mclk)
  begin
    if (!nrst || state_ff == ST_IDLE || tick)
      div_cnt_ff <= 8'h00;
    else
      div_cnt_ff <= div_cnt_ff + 8'h01;
  end

  // ==========================================
  // sequencer; no sleep or idle gating on purpose
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      tad_cnt_ff <= 5'h00;
      sample_ff <= 4'h0;
      convert_ff <= 1'b0;
      chan_ff <= 4'h0;
      sh_idx_ff <= 4'h0;
      raw_ff <= 12'h000;
      done_ff <= 1'b0;
    end
    else
    begin
      convert_ff <= 1'b0;
      if (wr_pend_ff && wr_addr_ff == `ASC_OFF_CON1 && hwdata[`ASC_C1_SAMP])
        done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          tad_cnt_ff <= 5'h00;
          sh_idx_ff <= 4'h0;
          if (module_on && samp_ff)
          begin
            state_ff <= ST_SAMPLE;
            sample_ff <= sh_mask;
          end
        end
        ST_SAMPLE:
        begin
          if (tick)
            tad_cnt_ff <= tad_cnt_ff + 5'h01;
          if (!module_on)
          begin
            state_ff <= ST_IDLE;
            sample_ff <= 4'h0;
          end
          else if (sample_end)
          begin
            state_ff <= ST_CONVERT;
            sample_ff <= 4'h0;
            tad_cnt_ff <= 5'h00;
            convert_ff <= 1'b1;
            chan_ff <= conv_control_two_ff[`ASC_C2_SCAN] ? scan_idx_ff : ch0_sel_ff;
          end
        end
        ST_CONVERT:
        begin
          if (tick)
            tad_cnt_ff <= tad_cnt_ff + 5'h01;
          if (!module_on)
            state_ff <= ST_IDLE;
          else if (tick && tad_cnt_ff >= conv_len - 5'h01)
          begin
            raw_ff <= afe_result;
            state_ff <= ST_STORE;
          end
        end
        ST_STORE:
        begin
          tad_cnt_ff <= 5'h00;
          if (last_sh)
          begin
            state_ff <= ST_IDLE;
            done_ff <= 1'b1;
          end
          else if (module_on)
          begin
            sh_idx_ff <= sh_idx_ff + 4'h1;
            chan_ff <= sh_idx_ff + 4'h1;
            convert_ff <= 1'b1;
            state_ff <= ST_CONVERT;
          end
          else
            state_ff <= ST_IDLE; // no new start once switched off
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // result buffer write, fill mode, sequence count and scan
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wr_ptr_ff <= 4'h0;
      seq_cnt_ff <= 4'h0;
      half_ff <= 1'b0;
      scan_idx_ff <= 4'h0;
    end
    else if (!module_on)
    begin
      wr_ptr_ff <= 4'h0;
      seq_cnt_ff <= 4'h0;
      half_ff <= 1'b0;
    end
    else if (state_ff == ST_STORE)
    begin
      buf_mem[wr_ptr_ff] <= fmt(raw_ff, afe_res12,
        conv_control_one_ff[`ASC_C1_FORM_HI:`ASC_C1_FORM_LO]);
      wr_ptr_ff <= wr_ptr_ff + 4'h1;
      if (last_sh)
      begin
        scan_idx_ff <= next_scan(scan_idx_ff, pin_analog_config_low_ff[NUM_AN-1:0]);
        if (seq_cnt_ff == conv_control_two_ff[`ASC_C2_SMPI_HI:`ASC_C2_SMPI_LO])
        begin
          seq_cnt_ff <= 4'h0;
          half_ff <= conv_control_two_ff[`ASC_C2_BUFM] & ~half_ff;
          wr_ptr_ff <= (conv_control_two_ff[`ASC_C2_BUFM] && !half_ff) ? 4'h8 : 4'h0;
        end
        else
          seq_cnt_ff <= seq_cnt_ff + 4'h1;
      end
    end
  end

  // pin mode: disabled module forces digital
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      digital_ff <= '1;
    else if (conv_module_disable_ff)
      digital_ff <= '1;
    else
      digital_ff <= ~pin_analog_config_low_ff[NUM_AN-1:0];
  end

  // front end power, registered alongside the start pulse
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      enable_ff <= 1'b0;
    else
      enable_ff <= module_on;
  end

  // ==========================================
  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign afe_enable = enable_ff;
  assign afe_ref_sel = conv_control_two_ff[`ASC_C2_VCFG_HI:`ASC_C2_VCFG_LO];
  assign afe_sample = sample_ff;
  assign afe_convert = convert_ff;
  assign afe_channel = chan_ff;
  assign pin_digital_mode = digital_ff;
  assign conv_interrupt_flag = flag_ff;
endmodule : asc_top

// >>> tb/asc_afe_model.sv
`timescale 1ns/1ps
// ==========================================
// analog front end stand-in
module asc_afe_model (
  // clock
  input wire logic mclk,
  // converter control
  input wire logic afe_enable,
  input wire logic afe_convert,
  input wire logic [3:0] afe_channel,
  // converter answer
  output logic [11:0] afe_result = 12'h5a5
);
  // code follows the channel from each start; garbles while powered down
  always @(posedge mclk)
  begin
    if (!afe_enable)
      afe_result <= ~afe_result;
    else if (afe_convert)
      afe_result <= {afe_channel, 8'h3c};
  end
endmodule : asc_afe_model

// >>> tb/asc_assertions.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the sequencer top
module asc_checker
  import asc_pkg::*;
#(
  parameter int NUM_AN = 13
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // front end
  input wire logic afe_enable,
  input wire logic afe_res12,
  input wire logic [3:0] afe_sample,
  input wire logic afe_convert,
  input wire logic [3:0] afe_channel,
  input wire logic conv_interrupt_flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // cycles since the last conversion start, saturating
  logic [7:0] gap_ff;
  logic [7:0] nxt_gap;
  always_comb
  begin
    nxt_gap = (gap_ff == 8'hff) ? gap_ff : gap_ff + 8'h01;
    if (afe_convert)
      nxt_gap = 8'h00;
  end
  always_ff @(posedge mclk)
  begin
    gap_ff <= nrst ? nxt_gap : 8'h00;
  end
  // a start pulse then a quiet converter
  sequence s_start;
    afe_convert ##0 afe_enable;
  endsequence
  sequence s_quiet;
    !afe_convert [*8];
  endsequence
  sequence s_off_twice;
    !afe_enable ##1 !afe_enable;
  endsequence
  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready okay");
  property p_one_sh;
    afe_res12 |-> $countones(afe_sample) <= 1;
  endproperty
  a_one_sh: assert property (p_one_sh) else $error("several holds in 12 bit");
  property p_sh_mask;
    !afe_res12 |-> afe_sample inside {4'h0, 4'h1, 4'h3, 4'hf};
  endproperty
  a_sh_mask: assert property (p_sh_mask) else $error("bad hold mask");
  property p_conv_gap;
    s_start |=> s_quiet;
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("starts too close");
  property p_conv_on;
    afe_convert |-> afe_enable;
  endproperty
  a_conv_on: assert property (p_conv_on) else $error("start while off");
  property p_chan_range;
    afe_convert |-> afe_channel < NUM_AN;
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("no such input");
  property p_off_idle;
    s_off_twice |-> afe_sample == 4'h0;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("sampling while off");
  property p_flag_late;
    $rose(conv_interrupt_flag) |-> gap_ff >= 8'h1e;
  endproperty
  a_flag_late: assert property (p_flag_late) else $error("flag before result");
endmodule : asc_checker

bind asc_top asc_checker #(.NUM_AN(NUM_AN)) u_chk (.mclk(mclk), .nrst(nrst),
  .hreadyout(hreadyout), .hresp(hresp), .afe_enable(afe_enable), .afe_res12(afe_res12),
  .afe_sample(afe_sample), .afe_convert(afe_convert), .afe_channel(afe_channel),
  .conv_interrupt_flag(conv_interrupt_flag));

// >>> tb/adc_sequencer_control_tb.sv
`timescale 1ns/1ps
`include "asc_map.svh"
module adc_sequencer_control_tb
  import asc_pkg::*;
;
  // ==========================================
  // stimulus and observed signals
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ext_trig = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rdv;
  logic hreadyout, hresp, afe_enable, afe_res12, afe_convert, conv_interrupt_flag;
  logic [11:0] afe_result;
  logic [2:0] afe_ref_sel;
  logic [3:0] afe_sample, afe_channel;
  logic [12:0] pin_digital_mode;
  int err_total = 0;
  int n_tests = 0;
  // clock
  always #12.5 mclk = ~mclk;
  asc_top dut (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_trig, .afe_result,
    .afe_enable, .afe_res12, .afe_ref_sel, .afe_sample, .afe_convert, .afe_channel,
    .pin_digital_mode, .conv_interrupt_flag);
  asc_afe_model u_afe (.mclk, .afe_enable, .afe_convert, .afe_channel, .afe_result);
  // ==========================================
  // shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // one single transfer, held until ready
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rdv = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rdv, e);
  endtask : rdc
  task wait_flag;
    int i;
    i = 0;
    while (conv_interrupt_flag !== 1'b1 && i < 3000)
    begin
      @(posedge mclk);
      i++;
    end
    chk(32'(conv_interrupt_flag), 32'h1);
  endtask : wait_flag
  // ==========================================
  // scenarios
  task t_reset;
    rdc(`ASC_OFF_CON1, 32'h0);
    rdc(8'h3c, 32'h0);
    chk(32'(pin_digital_mode), 32'h1fff);
    chk(32'(afe_enable), 32'h0);
  endtask : t_reset
  task t_format;
    logic [15:0] tab [4];
    tab = '{16'h003c, 16'hfe3c, 16'h0f00, 16'h8f00};
    wr(`ASC_OFF_PCFGL, 32'h1);
    wr(`ASC_OFF_CHSEL, 32'h0);
    for (int f = 0; f < 4; f++)
    begin
      wr(`ASC_OFF_CON1, {16'h0, 6'h20, f[1:0], 8'h02});
      tick(2);
      chk(32'(afe_sample), 32'h1);
      wr(`ASC_OFF_CON1, {16'h0, 6'h20, f[1:0], 8'h00});
      wait_flag();
      rdc(8'h40, {16'h0, tab[f]});
      rdc(`ASC_OFF_CON1, {16'h0, 6'h20, f[1:0], 8'h01});
      wr(`ASC_OFF_STAT, 32'h0);
      tick(1);
      chk(32'(conv_interrupt_flag), 32'h0);
    end
    chk(32'(pin_digital_mode), 32'h1ffe);
  endtask : t_format
  task t_sh;
    logic [3:0] m [3];
    m = '{4'h1, 4'h3, 4'hf};
    for (int c = 0; c < 3; c++)
    begin
      wr(`ASC_OFF_CON2, {22'h0, c[1:0], 8'h0});
      wr(`ASC_OFF_CON1, 32'h8002);
      tick(2);
      chk(32'(afe_sample), 32'(m[c]));
      wr(`ASC_OFF_CON1, 32'h0);
      tick(2);
      chk(32'(afe_sample), 32'h0);
    end
    wr(`ASC_OFF_CON1, 32'h8000);
    wr(`ASC_OFF_CON1, 32'h8400);
    rdc(`ASC_OFF_CON1, 32'h8000);
    wr(`ASC_OFF_CON1, 32'h0);
    wr(`ASC_OFF_CON1, 32'h0400);
    wr(`ASC_OFF_CON1, 32'h8402);
    tick(2);
    chk(32'(afe_res12), 32'h1);
    chk(32'(afe_sample), 32'h1);
    wr(`ASC_OFF_CON1, 32'h0400);
    wr(`ASC_OFF_CON1, 32'h0);
  endtask : t_sh
  task t_ref;
    for (int v = 0; v < 8; v++)
    begin
      wr(`ASC_OFF_CON2, {16'h0, v[2:0], 13'h0});
      tick(1);
      chk(32'(afe_ref_sel), 32'(v));
    end
    wr(`ASC_OFF_CON2, 32'h0);
  endtask : t_ref
  task t_trig;
    wr(`ASC_OFF_CON3, 32'h0102);
    wr(`ASC_OFF_CON1, 32'h80e2);
    wait_flag();
    wr(`ASC_OFF_STAT, 32'h0);
    wr(`ASC_OFF_CON1, 32'h8022);
    tick(60);
    chk(32'(afe_sample), 32'h1);
    chk(32'(conv_interrupt_flag), 32'h0);
    @(posedge mclk);
    ext_trig <= 1'b1;
    wait_flag();
    ext_trig <= 1'b0;
    wr(`ASC_OFF_STAT, 32'h0);
  endtask : t_trig
  task t_off;
    wr(`ASC_OFF_CON1, 32'h8000);
    wr(`ASC_OFF_PMD, 32'h1);
    tick(2);
    chk(32'(afe_enable), 32'h0);
    chk(32'(pin_digital_mode), 32'h1fff);
    wr(`ASC_OFF_PMD, 32'h0);
    tick(2);
    chk(32'(afe_enable), 32'h1);
  endtask : t_off
  // channel select range, scan over inputs 0 and 2, buffer halves, auto start
  task t_scan;
    wr(`ASC_OFF_CHSEL, 32'hd);
    rdc(`ASC_OFF_CHSEL, 32'h0);
    wr(`ASC_OFF_CHSEL, 32'hc);
    rdc(`ASC_OFF_CHSEL, 32'hc);
    wr(`ASC_OFF_CON1, 32'h0);
    wr(`ASC_OFF_PCFGL, 32'h5);
    wr(`ASC_OFF_CON2, 32'h0402);
    for (int s = 0; s < 2; s++)
    begin
      wr(`ASC_OFF_CON1, 32'h80e2);
      wait_flag();
      wr(`ASC_OFF_STAT, 32'h0);
    end
    rdc(8'h40, 32'h003c);
    rdc(8'h60, 32'h023c);
    rdc(`ASC_OFF_CON2, 32'h0402);
    wr(`ASC_OFF_CON1, 32'h80e4);
    wait_flag();
    wr(`ASC_OFF_CON1, 32'h0);
    wr(`ASC_OFF_STAT, 32'h0);
  endtask : t_scan
  // ==========================================
  // verdict and run control
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_format();
    t_sh();
    t_ref();
    t_trig();
    t_off();
    t_scan();
    end_sim();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    end_sim();
  end
endmodule : adc_sequencer_control_tb
